// File: rtl/bmux_pkg.sv
package bmux_pkg;

  // ==========================================================================
  // Register map
  localparam logic [11:0] IMUX_CFG_INDEX = 12'h017;
  localparam logic [11:0] IMUX_CFG_ADDR = 12'h05c;
  localparam logic [11:0] IMUX_STAT_ADDR = 12'h060;
  localparam int CFG_WIDTH = 24;

  // ==========================================================================
  // Field positions
  localparam int POS_ISO_P = 21;
  localparam int POS_ISO_N = 20;
  localparam int POS_CALP = 18;
  localparam int POS_CALN = 16;
  localparam int POS_CG = 12;
  localparam int POS_BIST = 11;
  localparam int POS_RNOM = 8;
  localparam int POS_MODULATED_RESISTANCE = 4;
  localparam int POS_FREQ = 0;

  // Writable bits and reset value
  localparam logic [23:0] CFG_WMASK = 24'h3f3f73;
  localparam logic [23:0] CFG_RESET = 24'h300040;

  // ==========================================================================
  // Calibration source codes
  localparam logic [1:0] CAL_NONE = 2'h0;
  localparam logic [1:0] CAL_MID = 2'h1;
  localparam logic [1:0] CAL_VHIGH = 2'h2;
  localparam logic [1:0] CAL_VLOW = 2'h3;

  // Modulation divider
  localparam int MOD_CNT_W = 19;
  localparam int MOD_TAP_BASE = 12;

endpackage

// File: rtl/cfg_if.sv
`timescale 1ns/1ps
interface cfg_if;
  logic [23:0] cfg;
  logic cal_gen_en;
  logic wave;
  modport ctrl (output cfg, output cal_gen_en, input wave);
  modport gen (input cfg, input cal_gen_en, output wave);
endinterface

// File: rtl/impedance_input_mux_config.sv
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ps
// Functional notes
// [R1] Bit 21 set isolates the positive impedance input, reset value 1.
// [R2] Bit 20 set isolates the negative impedance input, reset value 1.
// [R3] Bits 19:18 pick none, mid-supply, cal high or cal low for pos input.
// [R4] Bits 17:16 pick the same four sources for the negative input.
// [R5] Cal voltage codes route only while the cal generator is enabled.
// [R6] Bits 13:12 select the current generator chopping mode, reset 00.
// [R7] Software avoids resistive common-mode mode above 32 uA drive.
// [R8] Bit 11 enables the modulated-resistance self-test, reset 0.
// [R9] Self-test is active only while the cal generator enable is 0.
// [R10] Self-test opens drive isolation, closes drive-to-input, 200M bias.
// [R11] Software should open both input switches during self-test.
// [R12] Bits 10:8 pick the nominal self-test resistance, reset 000.
// [R13] Bits 6:4 pick modulation step; 1xx opens all modulation switches.
// [R14] Software never writes the reserved modulation code 011.
// [R15] Bits 1:0 divide the master clock by 2^13, 2^15, 2^17 or 2^19.
// [R16] Every modulation frequency is a 50 percent square wave.
// [R17] The toggle is a tap of a free-running 19-bit counter.
module impedance_input_mux_config (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Calibration generator enable from elsewhere
  input wire logic cal_gen_enable,
  // Input switch controls
  output logic pos_input_isolate,
  output logic neg_input_isolate,
  // Calibration source one-hots: none, mid, high, low
  output logic [3:0] pos_cal_route,
  output logic [3:0] neg_cal_route,
  // Current generator
  output logic [1:0] current_gen_chop_mode,
  // Self-test switch controls
  output logic selftest_active,
  output logic drive_iso_open,
  output logic drive_to_input_close,
  output logic lead_bias_200m,
  output logic [2:0] selftest_nominal_resistance,
  output logic [2:0] modulation_switches,
  output logic modulation_wave
);

  cfg_if cfg_bus ();

  logic [23:0] cfg_q;
  logic [23:0] cfg_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic acc;
  logic hit_cfg;
  logic hit_stat;
  logic [23:0] bmask;
  logic [3:0] pos_route_d;
  logic [3:0] neg_route_d;
  logic active_d;
  logic [2:0] modsw_d;
  logic [3:0] pos_route_q;
  logic [3:0] neg_route_q;
  logic active_q;
  logic [2:0] modsw_q;

  // ==========================================================================
  // APB decode
  always_comb begin
    acc = psel && penable;
    hit_cfg = 1'b0;
    hit_stat = 1'b0;
    if (paddr == bmux_pkg::IMUX_CFG_ADDR) begin
      hit_cfg = 1'b1;
    end else if (paddr == bmux_pkg::IMUX_STAT_ADDR) begin
      hit_stat = 1'b1;
    end
  end

  assign pready = 1'b1;
  assign pslverr = acc && !(hit_cfg || (hit_stat && !pwrite));

  // ==========================================================================
  // Configuration register
  always_comb begin
    bmask = {{8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    bmask = bmask & bmux_pkg::CFG_WMASK;
    cfg_d = cfg_q;
    if (acc && pwrite && hit_cfg) begin
      cfg_d = (cfg_q & ~bmask) | (pwdata[23:0] & bmask); // R1 R2 R8
    end
    rdata_d = rdata_q;
    if (psel && !penable && !pwrite) begin
      if (hit_cfg) begin
        rdata_d = {8'h00, cfg_q};
      end else if (hit_stat) begin
        rdata_d = {28'h0000000, cal_gen_enable, active_q,
          modulation_wave, 1'b0};
      end else begin
        rdata_d = 32'h00000000;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_q <= bmux_pkg::CFG_RESET;
      rdata_q <= 32'h00000000;
    end else begin
      cfg_q <= cfg_d;
      rdata_q <= rdata_d;
    end
  end

  assign prdata = rdata_q;

  // ==========================================================================
  // Decoded switch controls
  function automatic logic [3:0] route(input logic [1:0] sel,
                                       input logic vcal_ok);
    logic [3:0] r;
    r = 4'h0;
    case (sel)
      bmux_pkg::CAL_NONE: r = 4'h1;
      bmux_pkg::CAL_MID: r = 4'h2;
      bmux_pkg::CAL_VHIGH: r = vcal_ok ? 4'h4 : 4'h1;
      default: r = vcal_ok ? 4'h8 : 4'h1;
    endcase
    return r;
  endfunction

  always_comb begin
    pos_route_d = route(cfg_q[bmux_pkg::POS_CALP +: 2],
      cal_gen_enable); // R3 R5
    neg_route_d = route(cfg_q[bmux_pkg::POS_CALN +: 2],
      cal_gen_enable); // R4 R5
    active_d = cfg_q[bmux_pkg::POS_BIST] && !cal_gen_enable; // R8 R9
    modsw_d = 3'h0;
    if (active_d && !cfg_q[bmux_pkg::POS_MODULATED_RESISTANCE + 2] && modulation_wave) begin
      case (cfg_q[bmux_pkg::POS_MODULATED_RESISTANCE +: 2])
        2'h0: modsw_d = 3'h1;
        2'h1: modsw_d = 3'h2;
        2'h2: modsw_d = 3'h4;
        default: modsw_d = 3'h0;
      endcase // R13
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pos_route_q <= 4'h1;
      neg_route_q <= 4'h1;
      active_q <= 1'b0;
      modsw_q <= 3'h0;
    end else begin
      pos_route_q <= pos_route_d;
      neg_route_q <= neg_route_d;
      active_q <= active_d;
      modsw_q <= modsw_d;
    end
  end

  assign pos_input_isolate = cfg_q[bmux_pkg::POS_ISO_P]; // R1
  assign neg_input_isolate = cfg_q[bmux_pkg::POS_ISO_N]; // R2
  assign pos_cal_route = pos_route_q;
  assign neg_cal_route = neg_route_q;
  assign current_gen_chop_mode = cfg_q[bmux_pkg::POS_CG +: 2]; // R6
  assign selftest_active = active_q;
  assign drive_iso_open = active_q; // R10
  assign drive_to_input_close = active_q; // R10
  assign lead_bias_200m = active_q; // R10
  assign selftest_nominal_resistance = cfg_q[bmux_pkg::POS_RNOM +: 3]; // R12
  assign modulation_switches = modsw_q;
  assign cfg_bus.cfg = cfg_q;
  assign cfg_bus.cal_gen_en = cal_gen_enable;
  assign modulation_wave = cfg_bus.wave;

  selftest_modgen u_modgen (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .cfg_port(cfg_bus.gen)
  );

endmodule

// File: rtl/selftest_modgen.sv
`timescale 1ns/1ps
module selftest_modgen (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // Configuration
  cfg_if.gen cfg_port
);

  logic [bmux_pkg::MOD_CNT_W-1:0] cnt_q;
  logic [bmux_pkg::MOD_CNT_W-1:0] cnt_d;
  logic wave_q;
  logic wave_d;
  logic [1:0] freq;

  // ==========================================================================
  // Free-running counter, tap 12/14/16/18
  always_comb begin
    freq = cfg_port.cfg[bmux_pkg::POS_FREQ +: 2];
    cnt_d = cnt_q + 19'h00001; // R17
    wave_d = cnt_q[bmux_pkg::MOD_TAP_BASE + 2 * int'(freq)]; // R15 R16
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
      wave_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      wave_q <= wave_d;
    end
  end

  assign cfg_port.wave = wave_q;

endmodule

// File: tb/bmux_checker.sv
`timescale 1ns/1ps
module bmux_checker (
  // Watched ports
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic cal_gen_enable,
  input wire logic pos_input_isolate,
  input wire logic neg_input_isolate,
  input wire logic [3:0] pos_cal_route,
  input wire logic [1:0] current_gen_chop_mode,
  input wire logic selftest_active,
  input wire logic drive_iso_open,
  input wire logic [2:0] modulation_switches
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  logic wr;
  assign wr = psel && penable && pwrite && paddr == 12'h05c;
  a_pos_iso: assert property (wr && pstrb[2] |=>
    pos_input_isolate == $past(pwdata[21])) else $error("pos isolate");
  a_neg_iso: assert property (wr && pstrb[2] |=>
    neg_input_isolate == $past(pwdata[20])) else $error("neg isolate");
  a_chop_mode: assert property (wr && pstrb[1] |=>
    current_gen_chop_mode == $past(pwdata[13:12])) else $error("chop");
  a_route_onehot: assert property ($onehot(pos_cal_route))
    else $error("route not one-hot");
  a_cal_gate: assert property (!$past(cal_gen_enable) &&
    !$past(cal_gen_enable, 2) |-> pos_cal_route[3:2] == 2'h0)
    else $error("cal voltage routed");
  a_bist_gate: assert property (selftest_active |->
    !$past(cal_gen_enable)) else $error("self-test while cal on");
  a_bist_sw: assert property (drive_iso_open == selftest_active)
    else $error("drive isolation");
  a_mod_idle: assert property (!selftest_active &&
    !$past(selftest_active) |-> modulation_switches == 3'h0)
    else $error("modulation while idle");
endmodule
bind impedance_input_mux_config bmux_checker u_bmux_checker (.*);

// File: tb/test_impedance_input_mux_config.sv
`timescale 1ns/1ps
module test_impedance_input_mux_config;
  logic ref_clk = 0;
  logic arst_n = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic cal_gen_enable = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [3:0] pstrb = 0;
  logic [31:0] prdata, d, rs = 84;
  logic [3:0] pcr, ncr;
  logic pready, pslverr, piso, niso, act, dio, mwave, dtic, lb;
  logic [2:0] msw, nres;
  logic [1:0] cgm;
  logic [32:0] q[$];
  logic [32:0] e;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  int n;
  impedance_input_mux_config u_impedance_input_mux_config (
    .ref_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .cal_gen_enable,
    .pos_input_isolate(piso), .neg_input_isolate(niso),
    .pos_cal_route(pcr), .neg_cal_route(ncr), .current_gen_chop_mode(cgm),
    .selftest_active(act), .drive_iso_open(dio),
    .drive_to_input_close(dtic), .lead_bias_200m(lb),
    .selftest_nominal_resistance(nres), .modulation_switches(msw),
    .modulation_wave(mwave));
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] v, input logic [3:0] s);
    @(posedge ref_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    pstrb <= s;
    @(posedge ref_clk);
    penable <= 1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] x);
    q.push_back(x);
    apb(0, a, 32'h0, 4'h0);
  endtask
  task automatic settle();
    repeat (3) @(negedge ref_clk);
  endtask
  // Read monitor: oldest expectation against what the bus returns
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc > 90000) begin
      err_total++;
      give_verdict();
    end
    if (psel && penable && pready && !pwrite) begin
      e = q.pop_front();
      chk(pslverr, e[32]);
      if (!e[32]) chk(prdata, e[31:0]);
    end
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    arst_n <= 1;
    rd(12'h05c, 33'h000300040);
    rd(12'h010, 33'h100000000);
    repeat (4) begin
      d = rnd() & 32'hfff7ff;
      if (d[6:4] == 3'h3) d[6] = 1'b1;
      apb(1, 12'h05c, d, 4'hf);
      settle();
      chk(piso, d[21]);
      chk(niso, d[20]);
      chk(cgm, d[13:12]);
      chk(nres, d[10:8]);
      rd(12'h05c, {1'b0, d & 32'h3f3f73});
      apb(1, 12'h05c, 32'h0, 4'h4);
      rd(12'h05c, {1'b0, d & 32'h003f73});
    end
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      cal_gen_enable <= i[2];
      apb(1, 12'h05c, {12'h0, i[1:0], i[1:0], 16'h0}, 4'h4);
      settle();
      chk(pcr, (i[1] & ~i[2]) ? 4'h1 : 4'h1 << i[1:0]);
      chk(ncr, (i[1] & ~i[2]) ? 4'h1 : 4'h1 << i[1:0]);
    end
    @(posedge ref_clk);
    cal_gen_enable <= 1;
    apb(1, 12'h05c, 32'h300800, 4'h7);
    settle();
    chk(act, 1'b0);
    @(posedge ref_clk);
    cal_gen_enable <= 0;
    settle();
    chk(act, 1'b1);
    chk(dio, 1'b1);
    chk(dtic, 1'b1);
    chk(lb, 1'b1);
    for (int c = 0; c < 2; c++) begin
      apb(1, 12'h05c, 32'h300800 | c, 4'h7);
      settle();
      @(posedge mwave);
      @(negedge ref_clk);
      n = 0;
      while (mwave === 1'b1) begin
        @(negedge ref_clk);
        n++;
        if (n == 2) chk(msw, 3'h1);
      end
      chk(n, 32'h1000 << (2 * c));
      n = 0;
      while (c == 0 && mwave === 1'b0) begin
        @(negedge ref_clk);
        n++;
        if (n == 2) chk(msw, 3'h0);
      end
      if (c == 0) chk(n, 32'h1000);
    end
    give_verdict();
  end
endmodule
